// File: dv/atsm_host_model.sv
// Behavioural host that clocks the link, frames it and captures both data pins
`timescale 1ns/1ns
module atsm_host_model (
   // Link clock and frame sync to the device
   output logic      o_bclk,
   output logic      o_fsync,
   // Data pins and their enables from the device
   input  wire logic i_dout,
   input  wire logic i_dout_oe_n,
   input  wire logic i_sec,
   input  wire logic i_sec_oe_n
);
   logic cap_d  [0:1][0:1023];
   logic cap_oe [0:1][0:1023];

   // ---------------------------------------------------------------
   // Idle link: clock stands low between frames
   // ---------------------------------------------------------------
   initial begin
      o_bclk  = 1'b0;
      o_fsync = 1'b0;
   end

   // One frame or half: sync level, TDM pulse, capture base, bit count
   // Bits are taken just before each fall, clear of the pin delay
   task automatic half(input logic lvl, input bit pulse, input int base, input int n);
      // Pins move 10 ns clear of the system clock edges when the task starts on one
      #10 o_fsync = lvl;
      #200 o_bclk = 1'b1;
      #200;
      for (int k = 0; k < n; k++) begin
         o_bclk = 1'b0;
         #200 o_bclk = 1'b1;
         if (pulse && k == 0) o_fsync = 1'b0;
         #199;
         cap_d[0][base+k]  = i_dout;
         cap_oe[0][base+k] = i_dout_oe_n;
         cap_d[1][base+k]  = i_sec;
         cap_oe[1][base+k] = i_sec_oe_n;
         #1;
      end
      o_bclk = 1'b0;
   endtask
endmodule

// File: dv/atsm_top_tb_top.sv
// Register and link tests of the transmit slot mapper
`timescale 1ns/1ns
module atsm_top_tb_top;
   import atsm_pkg::*;
   logic        clk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] rd;
   logic        bclk;
   logic        fsync;
   logic        dout;
   logic        dout_oe_n;
   logic        sec;
   logic        sec_oe_n;
   int          n_fail;
   int          n_tests;
   // Distinct words so a wrong source shows at once
   localparam logic [31:0] W1 = 32'hA5C3_0F81;
   localparam logic [31:0] W2 = 32'h5A3C_F07E;
   localparam logic [31:0] W3 = 32'hC00F_FE13;
   localparam logic [31:0] WV = 32'h8E71_19D4;

   atsm_host_model HOST (
      .o_bclk(bclk), .o_fsync(fsync), .i_dout(dout), .i_dout_oe_n(dout_oe_n),
      .i_sec(sec), .i_sec_oe_n(sec_oe_n));

   atsm_top DUT (
      .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
      .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .i_ch1_sample(W1), .i_ch2_sample(W2), .i_mic3_sample(W3), .i_vbat_sample(WV),
      .i_bclk(bclk), .i_fsync(fsync), .o_dout(dout),
      .o_dout_oe_n(dout_oe_n), .o_secondary_serial_out(sec),
      .o_secondary_serial_out_oe_n(sec_oe_n));

   // ---------------------------------------------------------------
   // Clock, bus helpers and checks
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // One single AHB-Lite transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
      ahb(1'b0, idx, 32'h0);
      chk(rd, e);
      // Every access must answer OKAY
      chk({31'h0, hresp}, 32'h0000_0000);
   endtask

   // Gathers 32 captured bits, MSB first, of data or of enable
   function automatic logic [31:0] wd(input bit s, input int b, input bit oe);
      logic [31:0] w;
      for (int i = 0; i < 32; i++) w[31-i] = oe ? HOST.cap_oe[s][b+i] : HOST.cap_d[s][b+i];
      return w;
   endfunction

   task automatic slot_is(input bit s, input int b, input logic [31:0] e);
      chk(wd(s, b, 1'b0), e);
      chk(wd(s, b, 1'b1), 32'h0000_0000);
   endtask

   task automatic slot_off(input bit s, input int b);
      chk(wd(s, b, 1'b1), 32'hFFFF_FFFF);
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Whole run is near 0.8 ms of link traffic
   initial begin
      #3000000;
      n_fail++;
      give_verdict();
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      n_fail = 0;
      n_tests = 0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(IDX_LANE, 32'h0000_0000);
      rchk(IDX_CH1, 32'h0000_0020);
      rchk(IDX_CH2, 32'h0000_0021);
      rchk(IDX_CH3, 32'h0000_0002);
      // Format resets to TDM; status idle with both pins released
      rchk(IDX_FMT, 32'h0000_0000);
      rchk(IDX_STAT, 32'h0000_0000);
      rchk(8'h05, 32'h0000_0000);
      ahb(1'b1, IDX_LANE, 32'h0000_00FF);
      rchk(IDX_LANE, 32'h0000_00FF);
      $display("test registers done");
      // Default routing in TDM
      ahb(1'b1, IDX_LANE, 32'h0000_0000);
      HOST.half(1'b1, 1'b1, 0, 100);
      slot_is(0, 0, W1);
      slot_is(0, 32, W2);
      slot_off(0, 64);
      $display("test tdm defaults done");
      // Lanes, slot 31 and battery source; reserved bits written as zero
      ahb(1'b1, IDX_LANE, 32'h0000_0006);
      ahb(1'b1, IDX_CH1, 32'h0000_003F);
      ahb(1'b1, IDX_CH3, 32'h0000_0043);
      HOST.half(1'b1, 1'b1, 0, 1024);
      slot_is(0, 31 * 32, W1);
      slot_is(1, 32, W2);
      slot_off(0, 32);
      slot_is(1, 3 * 32, WV);
      $display("test lanes done");
      // Disabled channel and clash on one pin
      ahb(1'b1, IDX_LANE, 32'h0000_0000);
      ahb(1'b1, IDX_CH1, 32'h0000_0000);
      ahb(1'b1, IDX_CH2, 32'h0000_0020);
      ahb(1'b1, IDX_CH3, 32'h0000_0020);
      HOST.half(1'b1, 1'b1, 0, 40);
      slot_is(0, 0, W2);
      ahb(1'b1, IDX_CH2, 32'h0000_0000);
      HOST.half(1'b1, 1'b1, 0, 40);
      slot_is(0, 0, W3);
      $display("test clash done");
      // I2S: data one bit after each half start, left while sync low
      ahb(1'b1, IDX_FMT, 32'h0000_0001);
      ahb(1'b1, IDX_CH1, 32'h0000_0030);
      ahb(1'b1, IDX_CH2, 32'h0000_002E);
      ahb(1'b1, IDX_CH3, 32'h0000_0000);
      HOST.half(1'b1, 1'b0, 600, 4);
      HOST.half(1'b0, 1'b0, 0, 512);
      HOST.half(1'b1, 1'b0, 512, 40);
      slot_is(0, 14 * 32 + 1, W2);
      slot_is(0, 513, W1);
      $display("test i2s done");
      // Left-justified: left while sync high; reserved source stays off
      ahb(1'b1, IDX_FMT, 32'h0000_0002);
      ahb(1'b1, IDX_CH2, 32'h0000_0001);
      ahb(1'b1, IDX_CH3, 32'h0000_0062);
      HOST.half(1'b0, 1'b0, 600, 4);
      HOST.half(1'b1, 1'b0, 0, 96);
      HOST.half(1'b0, 1'b0, 512, 40);
      slot_off(0, 64);
      slot_is(0, 512, W1);
      $display("test left justified done");
      give_verdict();
   end
endmodule

// File: hdl/atsm_edge_if.sv
// Synchronised link clock edges and frame sync level
`timescale 1ns/1ns
interface atsm_edge_if;
   logic bclk_rise;
   logic bclk_fall;
   logic fsync;
   modport src (output bclk_rise, output bclk_fall, output fsync);
   modport dst (input bclk_rise, input bclk_fall, input fsync);
endinterface

// File: hdl/atsm_lane_pick.sv
// Picks the lowest-numbered channel owning the current slot on one lane
`timescale 1ns/1ns
module atsm_lane_pick
   import atsm_pkg::*;
#(
   parameter logic LANE = 1'b0
)
(
   // Slot being transmitted
   input  wire logic                     i_valid,
   input  wire logic [SLOT_W-1:0]        i_slot,
   // Channel settings
   input  wire logic [NUM_CH-1:0]        i_en,
   input  wire logic [NUM_CH-1:0]        i_lane,
   input  wire logic [NUM_CH*SLOT_W-1:0] i_slots,
   // Result
   output logic                          o_hit,
   output logic [1:0]                    o_idx,
   output logic [NUM_CH-1:0]             o_match
);
   // Per-channel slot compare
   for (genvar c = 0; c < NUM_CH; c++) begin : g_match
      assign o_match[c] = i_valid && i_en[c] && (i_lane[c] == LANE)
                          && (i_slots[c*SLOT_W +: SLOT_W] == i_slot);
   end

   // Lowest index wins so a clash never merges two words
   always_comb begin
      o_hit = |o_match;
      o_idx = 2'h0;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (o_match[c]) begin
            o_idx = c[1:0];
         end
      end
   end
endmodule

// File: hdl/atsm_pin_sync.sv
// Two-stage synchroniser and edge finder for the link clock and frame sync
`timescale 1ns/1ns
module atsm_pin_sync
   import atsm_pkg::*;
(
   // Clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   // Link pins
   input  wire logic  i_bclk,
   input  wire logic  i_fsync,
   // Events to the core
   atsm_edge_if.src   o_edge
);
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] sync;
      logic       bclk_old;
   } atsm_sync_t;

   atsm_sync_t st_ff;
   atsm_sync_t nxt_st;

   // Stage one feeds stage two only; edges come from stage two
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.meta     = {i_bclk, i_fsync};
      nxt_st.sync     = st_ff.meta;
      nxt_st.bclk_old = st_ff.sync[1];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // One-cycle edge pulses and the frame sync level
   assign o_edge.bclk_rise = st_ff.sync[1] & ~st_ff.bclk_old;
   assign o_edge.bclk_fall = ~st_ff.sync[1] & st_ff.bclk_old;
   assign o_edge.fsync     = st_ff.sync[0];
endmodule

// File: hdl/atsm_pkg.sv
// Constants and types shared by the audio transmit slot mapper
package atsm_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_LANE = 8'h1D;
   localparam logic [7:0] IDX_CH1  = 8'h1E;
   localparam logic [7:0] IDX_CH2  = 8'h1F;
   localparam logic [7:0] IDX_CH3  = 8'h20;
   localparam logic [7:0] IDX_FMT  = 8'h30;
   localparam logic [7:0] IDX_STAT = 8'h31;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_LANE = 8'h00;
   localparam logic [5:0] RST_CH1  = 6'h20;
   localparam logic [5:0] RST_CH2  = 6'h21;
   localparam logic [6:0] RST_CH3  = 7'h02;
   localparam logic [1:0] RST_FMT  = 2'h0;

   // ---------------------------------------------------------------
   // Field layout of the channel configuration registers
   // ---------------------------------------------------------------
   localparam int unsigned SLOT_W   = 5;
   localparam int unsigned EN_BIT   = 5;
   localparam int unsigned SRC_LSB  = 5;
   localparam logic [1:0]  SRC_OFF  = 2'h0;
   localparam logic [1:0]  SRC_MIC  = 2'h1;
   localparam logic [1:0]  SRC_VBAT = 2'h2;

   // ---------------------------------------------------------------
   // Framing
   // ---------------------------------------------------------------
   localparam logic [1:0]  FMT_TDM   = 2'h0;
   localparam logic [1:0]  FMT_I2S   = 2'h1;
   localparam logic [1:0]  FMT_LJ    = 2'h2;
   localparam int unsigned NUM_CH    = 3;
   localparam int unsigned NUM_LANE  = 2;
   localparam int unsigned WORD_W    = 32;
   localparam int unsigned CNT_W     = 10;
   localparam logic [9:0]  TDM_LAST  = 10'h3FF;
   localparam logic [9:0]  HALF_LAST = 10'h1FF;

   typedef enum logic [1:0] {PH_IDLE, PH_LEAD, PH_RUN} atsm_phase_t;

endpackage

// File: hdl/atsm_top.sv
// Transmit slot mapper: AHB-Lite registers, frame tracking and lane drive
//
// How it works
// - One bit per channel picks primary (0) or secondary (1) data pin.
// - Lane select register resets to zero, all channels on primary pin.
// - Channel 1 enable off tri-states its slot; on drives channel 1 samples.
// - Channel 2 enable off tri-states its slot; on drives channel 2 samples.
// - Five-bit slot field; in TDM value n selects slot n, 0 to 31.
// - In I2S or LJ, 0-15 pick left slots, 16-31 right slots 0-15.
// - Channel 1 resets enabled in slot 0, channel 2 enabled in slot 1.
// - Channel 3 configuration register resets to 0x02.
// - Channel 3 source: 0 off, 1 microphone 3, 2 battery voltage, 3 reserved.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module atsm_top
   import atsm_pkg::*;
(
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   // AHB-Lite slave
   input  wire logic               i_hsel,
   input  wire logic [31:0]        i_haddr,
   input  wire logic [1:0]         i_htrans,
   input  wire logic               i_hwrite,
   input  wire logic [2:0]         i_hsize,
   input  wire logic [31:0]        i_hwdata,
   input  wire logic               i_hready,
   output logic [31:0]             o_hrdata,
   output logic                    o_hreadyout,
   output logic                    o_hresp,
   // Sample words, same clock domain
   input  wire logic [WORD_W-1:0]  i_ch1_sample,
   input  wire logic [WORD_W-1:0]  i_ch2_sample,
   input  wire logic [WORD_W-1:0]  i_mic3_sample,
   input  wire logic [WORD_W-1:0]  i_vbat_sample,
   // Link pins
   input  wire logic               i_bclk,
   input  wire logic               i_fsync,
   output logic                    o_dout,
   output logic                    o_dout_oe_n,
   output logic                    o_secondary_serial_out,
   output logic                    o_secondary_serial_out_oe_n
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                   lane;
      logic [5:0]                   ch1;
      logic [5:0]                   ch2;
      logic [6:0]                   ch3;
      logic [1:0]                   fmt;
      logic                         wr_pend;
      logic [7:0]                   wr_idx;
      logic [31:0]                  rdata;
      logic                         fs_q;
      logic                         start_pend;
      atsm_phase_t                  phase;
      logic [CNT_W-1:0]             cnt;
      logic                         right;
      logic [NUM_CH-1:0][WORD_W-1:0] words;
      logic [NUM_LANE-1:0]          dout;
      logic [NUM_LANE-1:0]          oe_n;
   } atsm_state_t;

   atsm_state_t st_ff;
   atsm_state_t nxt_st;

   atsm_edge_if edge_bus ();

   logic                         addr_ok;
   logic                         is_tdm;
   logic                         is_i2s;
   logic                         slot_valid;
   logic [SLOT_W-1:0]            cur_slot;
   logic [4:0]                   bit_pos;
   logic [NUM_CH-1:0]            chan_en;
   logic [NUM_CH-1:0]            chan_lane;
   logic [NUM_CH*SLOT_W-1:0]     chan_slots;
   logic [NUM_LANE-1:0]          pick_hit;
   logic [NUM_LANE-1:0][1:0]     pick_idx;
   logic [NUM_LANE-1:0][NUM_CH-1:0] pick_match;

   // ---------------------------------------------------------------
   // Link pin synchroniser
   // ---------------------------------------------------------------
   atsm_pin_sync u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_bclk  (i_bclk),
      .i_fsync (i_fsync),
      .o_edge  (edge_bus.src)
   );

   // ---------------------------------------------------------------
   // Register read view
   // ---------------------------------------------------------------
   // Reserved bits read as zero whatever software wrote
   function automatic logic [31:0] read_reg(input logic [7:0] idx,
                                            input atsm_state_t s,
                                            input logic [7:0] stat);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (idx)
         IDX_LANE: v[7:0] = s.lane;
         IDX_CH1:  v[5:0] = s.ch1;
         IDX_CH2:  v[5:0] = s.ch2;
         IDX_CH3:  v[6:0] = s.ch3;
         IDX_FMT:  v[1:0] = s.fmt;
         IDX_STAT: v[7:0] = stat;
         default:  v      = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Slot decode from the bit counter
   // ---------------------------------------------------------------
   assign is_tdm  = (st_ff.fmt != FMT_I2S) && (st_ff.fmt != FMT_LJ);
   assign is_i2s  = (st_ff.fmt == FMT_I2S);
   assign bit_pos = st_ff.cnt[4:0];

   always_comb begin
      if (is_tdm) begin
         cur_slot   = st_ff.cnt[9:5];
         slot_valid = (st_ff.phase == PH_RUN);
      end else begin
         cur_slot   = {st_ff.right, st_ff.cnt[8:5]};
         slot_valid = (st_ff.phase == PH_RUN) && !st_ff.cnt[9];
      end
   end

   assign chan_en[0] = st_ff.ch1[EN_BIT];
   assign chan_en[1] = st_ff.ch2[EN_BIT];
   assign chan_en[2] = (st_ff.ch3[SRC_LSB +: 2] == SRC_MIC)
                       || (st_ff.ch3[SRC_LSB +: 2] == SRC_VBAT);

   // lane bits of the configured channels
   assign chan_lane  = st_ff.lane[NUM_CH-1:0];
   assign chan_slots = {st_ff.ch3[SLOT_W-1:0], st_ff.ch2[SLOT_W-1:0],
                        st_ff.ch1[SLOT_W-1:0]};

   // ---------------------------------------------------------------
   // Per-lane slot owner
   // ---------------------------------------------------------------
   for (genvar l = 0; l < NUM_LANE; l++) begin : g_lane
      atsm_lane_pick #(
         .LANE (1'(l))
      ) u_pick (
         .i_valid (slot_valid),
         .i_slot  (cur_slot),
         .i_en    (chan_en),
         .i_lane  (chan_lane),
         .i_slots (chan_slots),
         .o_hit   (pick_hit[l]),
         .o_idx   (pick_idx[l]),
         .o_match (pick_match[l])
      );
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   assign addr_ok = i_hsel && i_htrans[1] && i_hready;

   always_comb begin
      nxt_st = st_ff;

      if (st_ff.wr_pend) begin
         unique case (st_ff.wr_idx)
            IDX_LANE: nxt_st.lane = i_hwdata[7:0];
            IDX_CH1:  nxt_st.ch1  = i_hwdata[5:0];
            IDX_CH2:  nxt_st.ch2  = i_hwdata[5:0];
            IDX_CH3:  nxt_st.ch3  = i_hwdata[6:0];
            IDX_FMT:  nxt_st.fmt  = i_hwdata[1:0];
            default:  nxt_st.lane = st_ff.lane;
         endcase
      end

      // Address phase; read data uses the freshest register values
      nxt_st.wr_pend = addr_ok && i_hwrite;
      nxt_st.wr_idx  = i_haddr[9:2];
      if (addr_ok && !i_hwrite) begin
         nxt_st.rdata = read_reg(i_haddr[9:2], nxt_st,
                                 {~st_ff.oe_n, slot_valid, cur_slot});
      end

      // Frame start is caught on the rising link clock edge
      if (edge_bus.bclk_rise) begin
         nxt_st.fs_q = edge_bus.fsync;
         if (is_tdm ? (edge_bus.fsync && !st_ff.fs_q)
                    : (edge_bus.fsync != st_ff.fs_q)) begin
            nxt_st.start_pend = 1'b1;
         end
      end

      // Data moves on the falling edge; I2S waits one extra bit
      if (edge_bus.bclk_fall) begin
         if (st_ff.start_pend) begin
            nxt_st.start_pend = 1'b0;
            nxt_st.cnt        = '0;
            nxt_st.phase      = is_i2s ? PH_LEAD : PH_RUN;
            // left half is fsync low in I2S, high in LJ
            nxt_st.right      = is_tdm ? 1'b0 : (is_i2s ? st_ff.fs_q : !st_ff.fs_q);
            nxt_st.words[0]   = i_ch1_sample;
            nxt_st.words[1]   = i_ch2_sample;
            nxt_st.words[2]   = (st_ff.ch3[SRC_LSB +: 2] == SRC_VBAT) ? i_vbat_sample
                                                                     : i_mic3_sample;
         end else begin
            unique case (st_ff.phase)
               PH_IDLE: nxt_st.phase = PH_IDLE;
               PH_LEAD: nxt_st.phase = PH_RUN;
               PH_RUN: begin
                  if (st_ff.cnt == (is_tdm ? TDM_LAST : HALF_LAST)) begin
                     nxt_st.phase = PH_IDLE;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + 10'h001;
                  end
               end
            endcase
         end
      end

      // only the chosen owner drives each lane
      for (int l = 0; l < NUM_LANE; l++) begin
         nxt_st.oe_n[l] = !pick_hit[l];
         nxt_st.dout[l] = pick_hit[l] && st_ff.words[pick_idx[l]][~bit_pos];
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // full state reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_ff       <= '0;
         st_ff.lane  <= RST_LANE;
         st_ff.ch1   <= RST_CH1;
         st_ff.ch2   <= RST_CH2;
         st_ff.ch3   <= RST_CH3;
         st_ff.fmt   <= RST_FMT;
         st_ff.phase <= PH_IDLE;
         st_ff.oe_n  <= '1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Zero-wait slave; every access completes OKAY
   assign o_hreadyout                 = 1'b1;
   assign o_hresp                     = 1'b0;
   assign o_hrdata                    = st_ff.rdata;
   assign o_dout                      = st_ff.dout[0];
   assign o_dout_oe_n                 = st_ff.oe_n[0];
   assign o_secondary_serial_out      = st_ff.dout[1];
   assign o_secondary_serial_out_oe_n = st_ff.oe_n[1];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   a_lane_reset_zero: assert property ($past(i_rst) |-> st_ff.lane == RST_LANE)
      else $error("lane select not zero after reset");

   // channel 1 and 2 reset values
   a_ch12_reset_val: assert property ($past(i_rst) |->
      st_ff.ch1 == 6'h20 && st_ff.ch2 == 6'h21 && o_dout_oe_n)
      else $error("channel 1 or 2 reset value wrong");

   a_ch3_reset_val: assert property ($past(i_rst) |-> st_ff.ch3 == 7'h02)
      else $error("channel 3 reset value wrong");

   // secondary pin driven only by a channel routed there
   a_lane_route_ok: assert property (pick_hit[1] |->
      st_ff.lane[pick_idx[1]] ##1 !o_secondary_serial_out_oe_n)
      else $error("secondary pin driven by a primary channel");

   // disabled channel 1 never owns a slot
   a_ch1_off_quiet: assert property (!st_ff.ch1[EN_BIT] |->
      !pick_match[0][0] && !pick_match[1][0])
      else $error("disabled channel 1 drives a slot");

   // disabled channel 2 never owns a slot
   a_ch2_off_quiet: assert property (!st_ff.ch2[EN_BIT] |->
      !pick_match[0][1] && !pick_match[1][1])
      else $error("disabled channel 2 drives a slot");

   // TDM slot follows the bit counter in 32-bit steps
   a_tdm_slot_map: assert property (is_tdm && slot_valid && bit_pos == 5'h1F
      && edge_bus.bclk_fall && st_ff.cnt != TDM_LAST && !st_ff.start_pend
      |=> cur_slot == $past(cur_slot) + 5'h01)
      else $error("TDM slot did not advance");

   // right half selects slot values 16 to 31
   a_half_slot_map: assert property (!is_tdm && slot_valid |->
      cur_slot[4] == st_ff.right && cur_slot[3:0] == st_ff.cnt[8:5])
      else $error("half-frame slot mapping wrong");

   // channel 1 owns a slot only in the half named by its top slot bit
   a_half_ch1_map: assert property (!is_tdm && pick_match[0][0] |->
      st_ff.ch1[SLOT_W-1] == st_ff.right && st_ff.ch1[SLOT_W-2:0] == st_ff.cnt[8:5])
      else $error("channel 1 sent in the wrong half-frame slot");

   // primary pin driven only by a channel routed there
   a_pri_route_ok: assert property (pick_hit[0] |-> !st_ff.lane[pick_idx[0]])
      else $error("primary pin driven by a secondary channel");

   // outside a valid slot both pins are released on the next cycle
   a_idle_tristate: assert property (!slot_valid |=>
      o_dout_oe_n && o_secondary_serial_out_oe_n)
      else $error("pin driven outside a valid slot");

   // reserved bits of channel 1 always read back as zero
   a_reserved_zero: assert property (addr_ok && !i_hwrite && i_haddr[9:2] == IDX_CH1
      |=> o_hrdata[31:6] == 26'h0)
      else $error("reserved bits of channel 1 read nonzero");

   // off or reserved source never drives
   a_ch3_src_gate: assert property (st_ff.ch3[SRC_LSB +: 2] == SRC_OFF
      || st_ff.ch3[SRC_LSB +: 2] == 2'h3 |-> !pick_match[0][2] && !pick_match[1][2])
      else $error("channel 3 drives with no source");

   a_clash_lowest: assert property (pick_hit[0] && pick_idx[0] != 2'h0 |->
      !pick_match[0][0] && (pick_idx[0] == 2'h1 || !pick_match[0][1]))
      else $error("higher channel won a slot clash");

endmodule
